// file: src/fcs_pkg.sv
// Summary of operation
// - raster runs before and after the flips, applied to all three channels together
// - raster completion advances the sequencer and powers the x flip motor
// - after the flip time limit step on: x off, y on, then z
// - after the flips one more raster, then calibration complete drops sequencer power
// - starts come from ground command, survey or station timer; ignored while inhibit is set
// - survey command accepted only after four ground started calibrations
// - survey runs x, y, z subsequences: calibrate, survey, return, then complete
// - the survey runs only once per operation
// - binary survey counter steps per operation; decodes drive motors, mode, inhibit
// - flip power held a fixed interval per motor whether or not it moved
// - offset command latches a seven level code per channel in flip-flops
// - position inputs choose polarity of each channel bias; the offset code sets its level
// - a raster is two identical cycles of eight steps of ten seconds
// - gated slow step train drives a step counter feeding ladder switches, both polarities
// - after the second cycle the gate closes and step complete is signalled
// - offset ladders driven per channel, with inverted copies for polarity choice
// - calibration flips to half turn and back; survey adds gimbal and quarter turns
// - end of survey switch stops the electronic survey sequencing
// - flip and gimbal positions are monitored continuously, three and two per axis
// - an internal timing generator makes the step commands for all sequences
// - ground start command starts a calibration only while the inhibit is released; one sent during inhibit is dropped
package fcs_pkg;
   // ****************************************
   // timing
   // ****************************************
   localparam longint unsigned CLK_HZ = 200_000_000;
   localparam int unsigned STEP_TIME_S = 10; // one raster step
   localparam longint unsigned STEP_CYC_DEF = STEP_TIME_S * CLK_HZ;
   localparam int unsigned FLIP_TIME_S = 10; // flip power per motor
   localparam int unsigned FLIP_TICKS = FLIP_TIME_S / STEP_TIME_S;
   localparam int unsigned SV_TIME_S = 10; // survey and return phase length
   localparam int unsigned SV_TICKS = SV_TIME_S / STEP_TIME_S;
   // ****************************************
   // counts and codes
   // ****************************************
   localparam logic [2:0] RAST_LAST_STEP = 3'h7; // eight steps per cycle
   localparam logic [2:0] GC_NEED = 3'h4; // ground calibrations before survey
   localparam logic [3:0] SV_FIRST = 4'h1;
   localparam logic [3:0] SV_LAST = 4'h9;
   localparam logic [3:0] SV_DONE = 4'ha;
   localparam logic [3:0] TK_LAST_FLIP = 4'(FLIP_TICKS - 1);
   localparam logic [3:0] TK_LAST_SV = 4'(SV_TICKS - 1);

   typedef enum logic [2:0] {
      FC_IDLE = 3'b000,
      FC_RAST_PRE = 3'b001,
      FC_FLIP_X = 3'b010,
      FC_FLIP_Y = 3'b011,
      FC_FLIP_Z = 3'b100,
      FC_RAST_POST = 3'b101
   } fcs_state_t;
endpackage

// file: src/fcs_rast_if.sv
`timescale 1ns/10ps
// ****************************************
// sequencer to raster generator link
// ****************************************
interface fcs_rast_if;
   logic start; // one cycle request
   logic tick; // step train
   logic gate; // clock gate open
   logic done; // one cycle step complete
   logic [2:0] step;
   logic cyc;
   modport seq (output start, output tick, input gate, input done, input step, input cyc);
   modport gen (input start, input tick, output gate, output done, output step, output cyc);
endinterface

// file: src/fcs_raster.sv
`timescale 1ns/10ps
module fcs_raster (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   fcs_rast_if.gen r
);
   import fcs_pkg::*;

   typedef struct packed {
      logic gate;
      logic done;
      logic [2:0] step;
      logic cyc;
   } fcs_rast_t;

   fcs_rast_t s_reg, s_next;

   // ****************************************
   // gated step counter, two cycles of eight
   // ****************************************
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      if (r.start && !s_reg.gate) begin
         s_next.gate = 1'b1; // open gate
         s_next.step = 3'h0;
         s_next.cyc = 1'b0;
      end else if (s_reg.gate && r.tick) begin
         if (s_reg.step == RAST_LAST_STEP) begin
            s_next.step = 3'h0;
            if (s_reg.cyc) begin
               s_next.gate = 1'b0;
               s_next.done = 1'b1;
            end else begin
               s_next.cyc = 1'b1; // second identical cycle
            end
         end else begin
            s_next.step = s_reg.step + 3'h1;
         end
      end
   end

   // state register
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign r.gate = s_reg.gate;
   assign r.done = s_reg.done;
   assign r.step = s_reg.step;
   assign r.cyc = s_reg.cyc;

   // ****************************************
   // checks
   // ****************************************
   sequence s_last_step;
      s_reg.gate && r.tick && s_reg.step == RAST_LAST_STEP && s_reg.cyc;
   endsequence

   property p_rast_end;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_last_step |=> s_reg.done && !s_reg.gate ##1 !s_reg.done;
   endproperty
   a_rast_end: assert property (p_rast_end) else $error("raster did not end");

   property p_rast_step;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_reg.gate && r.tick && s_reg.step != RAST_LAST_STEP |=> s_reg.step == $past(s_reg.step) + 3'h1;
   endproperty
   a_rast_step: assert property (p_rast_step) else $error("raster step skipped");
endmodule

// file: src/fcs_top.sv
`timescale 1ns/10ps
module fcs_top #(
   parameter int unsigned STEP_CYC = 32'(fcs_pkg::STEP_CYC_DEF)
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic timer_req_i,
   input wire logic cmd3_offset_i,
   input wire logic cmd4_inhibit_i,
   input wire logic cmd5_start_i,
   input wire logic cmd7_survey_i,
   input wire logic [8:0] offset_code_i,
   input wire logic [8:0] flip_pos_i,
   input wire logic [5:0] gimbal_pos_i,
   input wire logic end_sw_i,
   output logic [2:0] flip_pwr_o,
   output logic [2:0] gimbal_pwr_o,
   output logic seq_pwr_o,
   output logic cal_complete_o,
   output logic cal_mode_o,
   output logic survey_mode_o,
   output logic seq_inhibit_o,
   output logic inhibit_o,
   output logic survey_done_o,
   output logic [2:0] ground_cnt_o,
   output logic [3:0] survey_cnt_o,
   output logic cal_gate_o,
   output logic [3:0] cal_sw_o,
   output logic cal_neg_o,
   output logic [8:0] offset_o,
   output logic [8:0] offset_n_o,
   output logic [2:0] bias_pos_o,
   output logic [2:0] bias_neg_o,
   output logic [8:0] flip_pos_o,
   output logic [5:0] gimbal_pos_o
);
   import fcs_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      fcs_state_t st;
      logic [31:0] pre;
      logic tick;
      logic [3:0] ftk;
      logic rstart;
      logic inhib;
      logic [2:0] gcnt;
      logic [3:0] svc;
      logic [3:0] svtk;
      logic svreq;
      logic svdone;
      logic [15:0] sy1;
      logic [15:0] sy2;
      logic [2:0] fpwr;
      logic [2:0] gpwr;
      logic cmpl;
      logic spwr;
      logic svm;
      logic cal_sw_gate;
      logic [3:0] cal_sw;
      logic cal_neg;
      logic [8:0] ofs;
      logic [8:0] ofs_n;
      logic [2:0] bpos;
      logic [2:0] bneg;
      logic [8:0] fpos;
      logic [5:0] gpos;
   } fcs_top_t;
   fcs_top_t s_reg, s_next;
   fcs_rast_if rif ();
   fcs_raster u_raster (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .r(rif.gen)
   );
   assign rif.start = s_reg.rstart;
   assign rif.tick = s_reg.tick;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic sv_act;
      logic sv_start;
      logic start_any;
      logic accept;
      logic [1:0] ax;
      logic [1:0] ph;
      logic [2:0] at180;
      s_next = s_reg;
      sv_act = 1'b0;
      sv_start = 1'b0;
      start_any = 1'b0;
      accept = 1'b0;
      ax = 2'h0;
      ph = 2'h0;
      at180 = 3'h0;
      s_next.cmpl = 1'b0;
      s_next.rstart = 1'b0;
      // position and end switch inputs pass two flops before use
      s_next.sy1 = {end_sw_i, gimbal_pos_i, flip_pos_i};
      s_next.sy2 = s_reg.sy1;
      // survey counter decode into axis and phase
      case (s_reg.svc)
         4'h1: begin ax = 2'h0; ph = 2'h0; end
         4'h2: begin ax = 2'h0; ph = 2'h1; end
         4'h3: begin ax = 2'h0; ph = 2'h2; end
         4'h4: begin ax = 2'h1; ph = 2'h0; end
         4'h5: begin ax = 2'h1; ph = 2'h1; end
         4'h6: begin ax = 2'h1; ph = 2'h2; end
         4'h7: begin ax = 2'h2; ph = 2'h0; end
         4'h8: begin ax = 2'h2; ph = 2'h1; end
         4'h9: begin ax = 2'h2; ph = 2'h2; end
         default: begin ax = 2'h0; ph = 2'h3; end
      endcase
      sv_act = s_reg.svm;
      // ground command toggles the start inhibit
      if (cmd4_inhibit_i) begin
         s_next.inhib = !s_reg.inhib;
      end
      // survey asks for a calibration at the head of each subsequence
      sv_start = sv_act && ph == 2'h0 && !s_reg.svreq && s_reg.st == FC_IDLE;
      start_any = sv_start || cmd5_start_i || (timer_req_i && !sv_act);
      accept = s_reg.st == FC_IDLE && start_any && !s_reg.inhib;

      // ****************************************
      // flip / calibration sequencer
      // ****************************************
      case (s_reg.st)
         FC_IDLE: begin
            if (accept) begin
               s_next.st = FC_RAST_PRE;
               s_next.rstart = 1'b1;
               if (sv_start) begin
                  s_next.svreq = 1'b1;
               end else if (cmd5_start_i && s_reg.gcnt != GC_NEED) begin
                  s_next.gcnt = s_reg.gcnt + 3'h1; // ground started count
               end
            end
         end
         FC_RAST_PRE: begin
            if (rif.done) begin
               s_next.st = FC_FLIP_X;
               s_next.ftk = 4'h0;
            end
         end
         FC_FLIP_X, FC_FLIP_Y, FC_FLIP_Z: begin
            // fixed time per motor, no position feedback
            if (s_reg.tick) begin
               if (s_reg.ftk == TK_LAST_FLIP) begin
                  s_next.ftk = 4'h0;
                  if (s_reg.st == FC_FLIP_X) begin
                     s_next.st = FC_FLIP_Y;
                  end else if (s_reg.st == FC_FLIP_Y) begin
                     s_next.st = FC_FLIP_Z;
                  end else begin
                     s_next.st = FC_RAST_POST;
                     s_next.rstart = 1'b1;
                  end
               end else begin
                  s_next.ftk = s_reg.ftk + 4'h1;
               end
            end
         end
         FC_RAST_POST: begin
            if (rif.done) begin
               s_next.st = FC_IDLE;
               s_next.cmpl = 1'b1;
            end
         end
         default: s_next.st = FC_IDLE;
      endcase

      // ****************************************
      // site survey counter
      // ****************************************
      if (s_reg.svc == 4'h0) begin
         // one shot, after four ground calibrations
         if (cmd7_survey_i && s_reg.gcnt == GC_NEED && !s_reg.svdone) begin
            s_next.svc = SV_FIRST;
            s_next.svtk = 4'h0;
         end
      end else if (sv_act) begin
         case (ph)
            2'h0: begin
               if (s_reg.svreq && s_reg.cmpl) begin
                  s_next.svc = s_reg.svc + 4'h1;
                  s_next.svreq = 1'b0;
               end
            end
            2'h1, 2'h2: begin
               if (s_reg.tick) begin
                  if (s_reg.svtk == TK_LAST_SV) begin
                     s_next.svc = s_reg.svc + 4'h1;
                     s_next.svtk = 4'h0;
                  end else begin
                     s_next.svtk = s_reg.svtk + 4'h1;
                  end
               end
            end
            default: s_next.svc = s_reg.svc;
         endcase
         if (s_reg.svc == SV_LAST && s_next.svc == SV_DONE) begin
            s_next.svdone = 1'b1;
         end
      end
      if (s_reg.sy2[15]) begin
         s_next.svc = 4'h0; // end switch stops survey
         s_next.svreq = 1'b0;
         s_next.svdone = 1'b1;
      end

      // ****************************************
      // timing generator, restarted on each step
      // ****************************************
      if (s_next.st != s_reg.st || s_next.svc != s_reg.svc) begin
         s_next.pre = 32'h0;
         s_next.tick = 1'b0;
      end else if (s_reg.pre == STEP_CYC - 32'h1) begin
         s_next.pre = 32'h0;
         s_next.tick = 1'b1;
      end else begin
         s_next.pre = s_reg.pre + 32'h1;
         s_next.tick = 1'b0;
      end

      // ****************************************
      // motor power decode
      // ****************************************
      s_next.fpwr = 3'h0;
      s_next.gpwr = 3'h0;
      // mode decodes registered so the outputs come straight from flops
      s_next.spwr = s_next.st != FC_IDLE;
      s_next.svm = s_next.svc >= SV_FIRST && s_next.svc <= SV_LAST;
      case (s_next.st)
         FC_FLIP_X: s_next.fpwr = 3'b001; // half turn and back
         FC_FLIP_Y: s_next.fpwr = 3'b010;
         FC_FLIP_Z: s_next.fpwr = 3'b100;
         default: s_next.fpwr = 3'h0;
      endcase
      if (s_next.svc == s_reg.svc && sv_act && ph != 2'h0) begin
         // survey phase: gimbal released, flip to survey stop, then return
         s_next.fpwr[ax] = 1'b1;
         if (ph == 2'h1) begin
            s_next.gpwr[ax] = 1'b1;
         end
      end

      // ****************************************
      // calibration ladder from raster step count
      // ****************************************
      s_next.cal_sw_gate = rif.gate;
      s_next.cal_sw = 4'h0;
      if (rif.gate) begin
         s_next.cal_sw[rif.step[1:0]] = 1'b1;
      end
      s_next.cal_neg = rif.gate && rif.step[2]; // second half negative

      // ****************************************
      // offset memory and transfer logic
      // ****************************************
      if (cmd3_offset_i) begin
         s_next.ofs = offset_code_i;
         s_next.ofs_n = ~offset_code_i;
      end
      s_next.fpos = s_reg.sy2[8:0];
      s_next.gpos = s_reg.sy2[14:9];
      at180 = {s_reg.sy2[8], s_reg.sy2[5], s_reg.sy2[2]};
      for (int i = 0; i < 3; i++) begin
         s_next.bpos[i] = s_next.ofs[3*i +: 3] != 3'h0 && !at180[i];
         s_next.bneg[i] = s_next.ofs[3*i +: 3] != 3'h0 && at180[i];
      end
   end

   // state register, all zero is idle scientific mode
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign flip_pwr_o = s_reg.fpwr;
   assign gimbal_pwr_o = s_reg.gpwr;
   assign seq_pwr_o = s_reg.spwr;
   assign cal_complete_o = s_reg.cmpl;
   assign cal_mode_o = s_reg.spwr;
   assign survey_mode_o = s_reg.svm;
   assign seq_inhibit_o = s_reg.svm;
   assign inhibit_o = s_reg.inhib;
   assign survey_done_o = s_reg.svdone;
   assign ground_cnt_o = s_reg.gcnt;
   assign survey_cnt_o = s_reg.svc;
   assign cal_gate_o = s_reg.cal_sw_gate;
   assign cal_sw_o = s_reg.cal_sw;
   assign cal_neg_o = s_reg.cal_neg;
   assign offset_o = s_reg.ofs;
   assign offset_n_o = s_reg.ofs_n;
   assign bias_pos_o = s_reg.bpos;
   assign bias_neg_o = s_reg.bneg;
   assign flip_pos_o = s_reg.fpos;
   assign gimbal_pos_o = s_reg.gpos;

   // ****************************************
   // checks
   // ****************************************
   sequence s_flip_x_end;
      s_reg.st == FC_FLIP_X && s_reg.tick && s_reg.ftk == TK_LAST_FLIP;
   endsequence
   sequence s_y_powered;
      s_reg.st == FC_FLIP_Y && flip_pwr_o == 3'b010;
   endsequence
   property p_start;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_reg.st == FC_IDLE && !s_reg.inhib && (cmd5_start_i || timer_req_i && !survey_mode_o)
      |=> s_reg.st == FC_RAST_PRE ##1 rif.gate;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_inhibit;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_reg.st == FC_IDLE && s_reg.inhib |=> s_reg.st == FC_IDLE;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("start while inhibited");
   property p_flip_x;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_reg.st == FC_RAST_PRE && rif.done |=> s_reg.st == FC_FLIP_X && flip_pwr_o == 3'b001;
   endproperty
   a_flip_x: assert property (p_flip_x) else $error("x flip not powered");
   property p_flip_y;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_flip_x_end |=> s_y_powered;
   endproperty
   a_flip_y: assert property (p_flip_y) else $error("y flip not next");
   property p_complete;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_reg.st == FC_RAST_POST && rif.done |=> cal_complete_o && !seq_pwr_o ##1 !cal_complete_o;
   endproperty
   a_complete: assert property (p_complete) else $error("no complete pulse");
   property p_survey_gate;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_reg.svc == 4'h0 && s_reg.gcnt != GC_NEED |=> s_reg.svc == 4'h0;
   endproperty
   a_survey_gate: assert property (p_survey_gate) else $error("survey too early");
   property p_end_sw;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      $rose(end_sw_i) |-> ##3 s_reg.svc == 4'h0 && survey_done_o;
   endproperty
   a_end_sw: assert property (p_end_sw) else $error("end switch ignored");
   property p_offset;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      cmd3_offset_i |=> offset_o == $past(offset_code_i) && offset_n_o == ~offset_o;
   endproperty
   a_offset: assert property (p_offset) else $error("offset not latched");
   property p_one_flip;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      $onehot0(flip_pwr_o);
   endproperty
   a_one_flip: assert property (p_one_flip) else $error("two flip motors on");
endmodule

// file: test/fcs_gnd_model.sv
`timescale 1ns/10ps
// ****************************************
// ground command source and station timer
// ****************************************
module fcs_gnd_model #(
   parameter int unsigned PERIOD = 40
) (
   input wire logic clk_sys_i,
   input wire logic timer_en_i,
   output logic timer_req_o,
   output logic [7:0] cmd_o
);
   int unsigned tcnt = 0;
   // idle lines at time zero
   initial begin
      timer_req_o = 1'b0;
      cmd_o = 8'h00;
   end
   // one request every PERIOD cycles while enabled
   always @(negedge clk_sys_i) begin
      tcnt <= (timer_en_i && tcnt < PERIOD - 1) ? tcnt + 1 : 0;
      timer_req_o <= timer_en_i && tcnt == PERIOD - 1;
   end
   // command strobe high for one cycle, then one idle cycle
   task automatic send(input int n);
      @(negedge clk_sys_i);
      cmd_o[n] = 1'b1;
      @(negedge clk_sys_i);
      cmd_o = 8'h00;
      @(negedge clk_sys_i);
   endtask
endmodule

// file: test/fcs_top_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
`define WAITC(nm, c, n) begin k = 0; while (!(c) && k < (n)) begin \
   @(negedge clk_sys_i); k++; end \
   if (!(c)) begin n_errors++; $display("[ERR] %s timed out", nm); stop_test(); end end
// ****************************************
// sequencer bench
// ****************************************
module fcs_top_bench;
   localparam int unsigned S = 8;
   logic clk_sys_i = 1'b0;
   logic nrst_i;
   logic timer_en;
   logic timer_req;
   logic [7:0] cmd;
   logic [8:0] offset_code;
   logic [8:0] flip_pos;
   logic [5:0] gimbal_pos;
   logic end_sw;
   logic [2:0] flip_pwr, gimbal_pwr, bias_pos, bias_neg, ground_cnt;
   logic seq_pwr, cal_complete, survey_mode, inhibit, survey_done, cal_neg;
   logic cal_mode, seq_inhibit, cal_gate;
   logic [3:0] survey_cnt, cal_sw, prev4;
   logic [8:0] offset, offset_n, flip_pos_o;
   logic [5:0] gimbal_pos_o;
   int n_errors = 0;
   int n_tests = 0;
   int k;
   int i;
   // clock, 5 ns period
   always #2.5 clk_sys_i = ~clk_sys_i;
   fcs_gnd_model #(.PERIOD(40)) gm (.clk_sys_i(clk_sys_i), .timer_en_i(timer_en),
      .timer_req_o(timer_req), .cmd_o(cmd));
   fcs_top #(.STEP_CYC(S)) dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .timer_req_i(timer_req), .cmd3_offset_i(cmd[3]), .cmd4_inhibit_i(cmd[4]),
      .cmd5_start_i(cmd[5]), .cmd7_survey_i(cmd[7]), .offset_code_i(offset_code),
      .flip_pos_i(flip_pos), .gimbal_pos_i(gimbal_pos), .end_sw_i(end_sw),
      .flip_pwr_o(flip_pwr), .gimbal_pwr_o(gimbal_pwr), .seq_pwr_o(seq_pwr),
      .cal_complete_o(cal_complete), .cal_mode_o(cal_mode), .survey_mode_o(survey_mode),
      .seq_inhibit_o(seq_inhibit), .inhibit_o(inhibit), .survey_done_o(survey_done),
      .ground_cnt_o(ground_cnt), .survey_cnt_o(survey_cnt), .cal_gate_o(cal_gate),
      .cal_sw_o(cal_sw), .cal_neg_o(cal_neg), .offset_o(offset), .offset_n_o(offset_n),
      .bias_pos_o(bias_pos), .bias_neg_o(bias_neg), .flip_pos_o(flip_pos_o),
      .gimbal_pos_o(gimbal_pos_o));
   // counts, verdict and end of run
   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // count polarity swings of one raster
   task automatic raster(input string nm);
      int r;
      logic prev;
      r = 0;
      prev = cal_neg;
      k = 0;
      while (flip_pwr === 3'h0 && cal_complete !== 1'b1 && k < 40 * S) begin
         @(negedge clk_sys_i);
         k++;
         r += (cal_neg === 1'b1 && prev === 1'b0);
         prev = cal_neg;
         `CHK("cal_sw_onehot", 1'b1, 1'($onehot0(cal_sw)))
         `CHK("cal_gate", 1'(cal_sw != 4'h0), cal_gate)
      end
      `CHK("raster_bound", 1'b1, 1'(k < 40 * S))
      `CHK(nm, 2, r)
   endtask
   // one ground started calibration, with a refused second start
   task automatic run_cal(input logic [2:0] gc);
      int a;
      int n;
      gm.send(5);
      `CHK("seq_pwr", 1'b1, seq_pwr)
      `CHK("cal_mode", 1'b1, cal_mode)
      gm.send(5);
      `CHK("ground_cnt", gc, ground_cnt)
      raster("pre_rises");
      for (a = 0; a < 3; a++) begin
         `CHK("flip_pwr", 3'(1 << a), flip_pwr)
         `CHK("cal_gimbal", 3'h0, gimbal_pwr)
         n = 0;
         while (flip_pwr === 3'(1 << a) && n < 4 * S) begin
            @(negedge clk_sys_i);
            n++;
         end
         `CHK("flip_time", S + 1, n) // one step plus the registered tick
      end
      raster("post_rises");
      `CHK("cal_complete", 1'b1, cal_complete)
      `CHK("seq_pwr_off", 1'b0, seq_pwr)
      `CHK("cal_gate_off", 1'b0, cal_gate)
   endtask
   // main sequence
   initial begin
      nrst_i = 1'b0;
      timer_en = 1'b0;
      offset_code = 9'h000;
      flip_pos = 9'h049;
      gimbal_pos = 6'h15;
      end_sw = 1'b0;
      repeat (5) @(negedge clk_sys_i);
      nrst_i = 1'b1;
      `CHK("seq_pwr", 1'b0, seq_pwr)
      `CHK("survey_cnt", 4'h0, survey_cnt)
      `CHK("offset_n", 9'h000, offset_n)
      $display("test reset finished");
      offset_code = 9'h0c5;
      flip_pos = 9'h109;
      gimbal_pos = 6'h2a;
      gm.send(3);
      repeat (4) @(negedge clk_sys_i);
      `CHK("offset", 9'h0c5, offset)
      `CHK("offset_n", 9'h13a, offset_n)
      `CHK("bias_pos", 3'h1, bias_pos)
      `CHK("bias_neg", 3'h4, bias_neg)
      `CHK("flip_pos_o", 9'h109, flip_pos_o)
      `CHK("gimbal_pos_o", 6'h2a, gimbal_pos_o)
      offset_code = 9'h1ff;
      flip_pos = 9'h049;
      repeat (2) @(negedge clk_sys_i);
      `CHK("offset_hold", 9'h0c5, offset)
      $display("test offset finished");
      gm.send(4);
      `CHK("inhibit", 1'b1, inhibit)
      gm.send(5);
      timer_en <= 1'b1;
      repeat (100) @(negedge clk_sys_i);
      timer_en <= 1'b0;
      `CHK("seq_pwr", 1'b0, seq_pwr)
      gm.send(4);
      `CHK("inhibit", 1'b0, inhibit)
      timer_en <= 1'b1;
      `WAITC("timer_start", seq_pwr === 1'b1, 100)
      timer_en <= 1'b0;
      `CHK("ground_cnt", 3'h0, ground_cnt)
      `WAITC("timer_cal", seq_pwr === 1'b0, 60 * S)
      $display("test starts finished");
      for (i = 1; i <= 4; i++) begin
         run_cal(3'(i));
         if (i == 1) begin
            gm.send(7);
            `CHK("survey_early", 4'h0, survey_cnt)
         end
      end
      gm.send(7);
      `CHK("survey_cnt", 4'h1, survey_cnt)
      `CHK("survey_mode", 1'b1, survey_mode)
      `CHK("seq_inhibit", 1'b1, seq_inhibit)
      prev4 = 4'h1;
      k = 0;
      while (survey_cnt !== 4'ha && k < 4000) begin
         @(negedge clk_sys_i);
         k++;
         if (survey_cnt !== prev4) begin
            `CHK("survey_step", prev4 + 4'h1, survey_cnt)
            prev4 = survey_cnt;
         end
      end
      `CHK("survey_done", 1'b1, survey_done)
      gm.send(7);
      `CHK("survey_once", 4'ha, survey_cnt)
      $display("test survey finished");
      nrst_i = 1'b0;
      repeat (5) @(negedge clk_sys_i);
      `CHK("ground_cnt", 3'h0, ground_cnt)
      `CHK("survey_done", 1'b0, survey_done)
      nrst_i = 1'b1;
      for (i = 1; i <= 4; i++) begin
         run_cal(3'(i));
      end
      gm.send(7);
      `WAITC("survey_x", survey_cnt === 4'h2, 40 * S)
      @(negedge clk_sys_i);
      `CHK("survey_flip", 3'h1, flip_pwr)
      `CHK("survey_gimbal", 3'h1, gimbal_pwr)
      `CHK("cal_mode_sv", 1'b0, cal_mode)
      end_sw = 1'b1;
      repeat (5) @(negedge clk_sys_i);
      `CHK("survey_cnt", 4'h0, survey_cnt)
      `CHK("survey_done", 1'b1, survey_done)
      `CHK("survey_mode_off", 1'b0, survey_mode)
      `CHK("survey_stop", 3'h0, flip_pwr)
      end_sw = 1'b0;
      $display("test end switch finished");
      stop_test();
   end
endmodule
